// ==== design/fsp_pkg.sv ====
// Constants shared by the fan speed PWM generator and its divider
package fsp_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [3:0] ADDR_PRESCALE = 4'h0; // Clock select and divider
    localparam logic [3:0] ADDR_DUTY     = 4'h4; // Duty value
    localparam logic [3:0] ADDR_CONTROL  = 4'h8; // Enable and invert
    localparam logic [3:0] ADDR_STATUS   = 4'hc; // Live counter and levels

    // Prescale register layout
    localparam int         PRESCALE_W     = 7;     // Divider field width
    localparam int         CLK_SEL_BIT    = 7;     // Source select position
    localparam logic [7:0] PRESCALE_RESET = 8'h00; // Fast source, divide by 1

    // Duty register layout
    localparam int         COUNT_W    = 8;     // Counter and duty width
    localparam logic [7:0] DUTY_RESET = 8'hff; // Full on after reset
    localparam logic [7:0] DUTY_ZERO  = 8'h00; // Always low
    localparam logic [7:0] DUTY_FULL  = 8'hff; // Always high

    // Control register layout
    localparam int         CTRL_EN_BIT  = 0;     // Generator enable
    localparam int         CTRL_INV_BIT = 1;     // Invert fan drive
    localparam logic [1:0] CTRL_RESET   = 2'h0;  // Disabled, not inverted

    // Status register layout
    localparam int STAT_PWM_BIT = 8; // Modulated level
    localparam int STAT_FAN_BIT = 9; // Fan drive level

    // Rates in KHz: system clock and the two selectable sources
    localparam int CLK_KHZ      = 40000; // 40 MHz, 25 ns period
    localparam int SRC_FAST_KHZ = 24000; // 24 MHz source
    localparam int SRC_SLOW_KHZ = 200;   // 200 KHz source
    localparam int ACC_W        = 17;    // Phase accumulator width

    // Cycles between slow source ticks, derived from the rates
    localparam int SLOW_GAP_CYC = CLK_KHZ / SRC_SLOW_KHZ;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/fsp_div_if.sv ====
// Carrier between the register side and the counter clock divider
`timescale 1ns/100ps
`default_nettype none
interface fsp_div_if;
    logic       enable;   // Generator running
    logic       clkSel;   // 0 fast source, 1 slow source
    logic [6:0] prescale; // Divide by this plus one
    logic       cntTick;  // One-cycle counter clock enable

    // Register side drives settings, reads the tick
    modport ctrl (output enable, output clkSel, output prescale,
                  input cntTick);
    // Divider side reads settings, drives the tick
    modport div  (input enable, input clkSel, input prescale,
                  output cntTick);
endinterface
`default_nettype wire

// ==== design/fsp_clk_div.sv ====
// Source tick generator and programmable prescaler for the PWM counter
`timescale 1ns/100ps
`default_nettype none
module fsp_clk_div (
    input  wire logic mclk,
    input  wire logic rst_n,
    fsp_div_if.div    bus
);
    localparam int SW = fsp_pkg::ACC_W;

    logic [SW-1:0] acc_r;       // Phase accumulator
    logic [SW-1:0] accSum;      // Accumulator plus step
    logic [SW-1:0] step;        // Step for the chosen source
    logic          srcTick;     // Source clock enable
    logic [6:0]    divCount_r;  // Source ticks since last counter tick

    // Fractional rate: 40 MHz cannot be divided to 24 MHz by an integer
    always_comb begin
        step    = bus.clkSel ? SW'(fsp_pkg::SRC_SLOW_KHZ)
                             : SW'(fsp_pkg::SRC_FAST_KHZ);
        accSum  = acc_r + step;
        srcTick = bus.enable && (accSum >= SW'(fsp_pkg::CLK_KHZ));
    end

    // Accumulator cleared while disabled so the first period is clean
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= '0;
        end else if (!bus.enable) begin
            acc_r <= '0;
        end else if (srcTick) begin
            acc_r <= accSum - SW'(fsp_pkg::CLK_KHZ);
        end else begin
            acc_r <= accSum;
        end
    end

    // Divider counts source ticks up to the prescale field
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCount_r <= 7'h00;
        end else if (!bus.enable) begin
            divCount_r <= 7'h00;
        end else if (srcTick) begin
            if (divCount_r == bus.prescale) begin
                divCount_r <= 7'h00;
            end else begin
                divCount_r <= divCount_r + 7'h01;
            end
        end
    end

    // Zero field passes every source tick straight through
    assign bus.cntTick = srcTick && (divCount_r == bus.prescale);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    fast_src_rate_a: assert property (
        bus.enable && !bus.clkSel |-> ##[0:1] (srcTick || !bus.enable))
        else $error("fast source tick missing");
    slow_src_gap_a: assert property (
        bus.clkSel && srcTick |=> !srcTick [*8])
        else $error("slow source ticks too close");
    div_ratio_a: assert property (
        bus.enable && srcTick && divCount_r != bus.prescale
            |-> !bus.cntTick ##1 divCount_r == $past(divCount_r) + 7'h01)
        else $error("divider stepped wrongly");
    bypass_tick_a: assert property (
        bus.enable && bus.prescale == 7'h00 && srcTick |-> bus.cntTick)
        else $error("zero prescale did not bypass");
endmodule
`default_nettype wire

// ==== design/fsp_pwm_top.sv ====
// Fan speed PWM generator with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
// Contract
// - 8-bit counter wraps, period 256 ticks
// - Output high while count below duty
// - Duty zero always low, all ones high
// - Invert bit complements fan drive output
// - Counter clock divides selectable 24M/200K source
// - Divide ratio is prescale field plus one
// - Clock select resets to 24 MHz
// - Select bit 7: 0 fast, 1 slow
// - Zero field bypasses; codes 7Ch-7Fh forbidden; the prescale register stores them unfiltered
// - Duty resets all ones; code counts high ticks
module fsp_pwm_top #(
    parameter int ADDR_W = 4 // AXI address width
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   fanDriveOutput
);
    // Refuse address widths that cannot reach the status word
    if (ADDR_W < 4) begin : gBadAddr
        $error("ADDR_W must be at least 4");
    end

    // Register selects produced by the address decoder
    typedef enum logic [2:0] {
        FSP_SEL_PRESCALE = 3'h0,
        FSP_SEL_DUTY     = 3'h1,
        FSP_SEL_CONTROL  = 3'h2,
        FSP_SEL_STATUS   = 3'h3,
        FSP_SEL_NONE     = 3'h4
    } fsp_sel_e;

    // Shared by write and read paths; upper bits must be zero
    function automatic fsp_sel_e decodeAddr(input logic [ADDR_W-1:0] a);
        logic [3:0] lo;
        lo = a[3:0];
        if ((a >> 4) != '0) begin
            decodeAddr = FSP_SEL_NONE;
        end else begin
            case (lo)
                fsp_pkg::ADDR_PRESCALE: decodeAddr = FSP_SEL_PRESCALE;
                fsp_pkg::ADDR_DUTY:     decodeAddr = FSP_SEL_DUTY;
                fsp_pkg::ADDR_CONTROL:  decodeAddr = FSP_SEL_CONTROL;
                fsp_pkg::ADDR_STATUS:   decodeAddr = FSP_SEL_STATUS;
                default:                decodeAddr = FSP_SEL_NONE;
            endcase
        end
    endfunction

    // Write channel holding registers
    logic [ADDR_W-1:0] awAddr_r;   // Captured write address
    logic              awHave_r;   // Write address held
    logic [7:0]        wData_r;    // Captured low data byte
    logic              wStrb0_r;   // Low byte lane enabled
    logic              wHave_r;    // Write data held
    logic              bValid_r;   // Write response pending
    logic [1:0]        bResp_r;    // Write response code
    logic              doWrite;    // Both halves present, commit now
    fsp_sel_e          wSel;       // Decoded write target

    // Read channel registers
    logic              rValid_r;   // Read data pending
    logic [31:0]       rData_r;    // Read data word
    logic [1:0]        rResp_r;    // Read response code
    logic [31:0]       rWord;      // Read mux output
    fsp_sel_e          rSel;       // Decoded read target

    // Software visible state
    logic [7:0]        prescale_r; // Clock select and divider field
    logic [7:0]        duty_r;     // Duty value
    logic              enable_r;   // Generator enable
    logic              invert_r;   // Fan drive inversion

    // PWM datapath
    logic [7:0]        count_r;    // Free running PWM counter
    logic              pwmNxt;     // Next modulated level
    logic              pwmLevel_r; // Modulated level
    logic              fanDrive_r; // Fan drive output register

    // Divider link
    fsp_div_if divBus ();

    fsp_clk_div uDiv (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (divBus)
    );

    assign divBus.enable   = enable_r;
    assign divBus.clkSel   = prescale_r[fsp_pkg::CLK_SEL_BIT];
    assign divBus.prescale = prescale_r[fsp_pkg::PRESCALE_W-1:0];

    // Handshake outputs follow the holding flags
    assign s_axi_awready = !awHave_r;
    assign s_axi_wready  = !wHave_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;
    assign fanDriveOutput = fanDrive_r;

    // Commit only once the previous response has been taken
    assign doWrite = awHave_r && wHave_r && !bValid_r;
    assign wSel    = decodeAddr(awAddr_r);
    assign rSel    = decodeAddr(s_axi_araddr);

    // Address and data may arrive in either order
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awAddr_r <= '0;
            awHave_r <= 1'b0;
        end else if (s_axi_awvalid && !awHave_r) begin
            awAddr_r <= s_axi_awaddr;
            awHave_r <= 1'b1;
        end else if (doWrite) begin
            awHave_r <= 1'b0;
        end
    end

    // Only byte lane 0 carries register bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wData_r  <= 8'h00;
            wStrb0_r <= 1'b0;
            wHave_r  <= 1'b0;
        end else if (s_axi_wvalid && !wHave_r) begin
            wData_r  <= s_axi_wdata[7:0];
            wStrb0_r <= s_axi_wstrb[0];
            wHave_r  <= 1'b1;
        end else if (doWrite) begin
            wHave_r <= 1'b0;
        end
    end

    // Write response, error for unmapped or read-only targets
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bValid_r <= 1'b0;
            bResp_r  <= fsp_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bValid_r <= 1'b1;
            if (wSel == FSP_SEL_NONE || wSel == FSP_SEL_STATUS) begin
                bResp_r <= fsp_pkg::RESP_SLVERR;
            end else begin
                bResp_r <= fsp_pkg::RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            bValid_r <= 1'b0;
        end
    end

    // Prescale register; reserved codes are not filtered here
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_r <= fsp_pkg::PRESCALE_RESET;
        end else if (doWrite && wStrb0_r && wSel == FSP_SEL_PRESCALE) begin
            prescale_r <= wData_r;
        end
    end

    // Duty register may change at any time, glitch risk accepted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            duty_r <= fsp_pkg::DUTY_RESET;
        end else if (doWrite && wStrb0_r && wSel == FSP_SEL_DUTY) begin
            duty_r <= wData_r;
        end
    end

    // Control bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= fsp_pkg::CTRL_RESET[fsp_pkg::CTRL_EN_BIT];
            invert_r <= fsp_pkg::CTRL_RESET[fsp_pkg::CTRL_INV_BIT];
        end else if (doWrite && wStrb0_r && wSel == FSP_SEL_CONTROL) begin
            enable_r <= wData_r[fsp_pkg::CTRL_EN_BIT];
            invert_r <= wData_r[fsp_pkg::CTRL_INV_BIT];
        end
    end

    // Read mux, status shows live counter and output levels
    always_comb begin
        rWord = 32'h0000_0000;
        case (rSel)
            FSP_SEL_PRESCALE: rWord[7:0] = prescale_r;
            FSP_SEL_DUTY:     rWord[7:0] = duty_r;
            FSP_SEL_CONTROL: begin
                rWord[fsp_pkg::CTRL_EN_BIT]  = enable_r;
                rWord[fsp_pkg::CTRL_INV_BIT] = invert_r;
            end
            FSP_SEL_STATUS: begin
                rWord[7:0]                   = count_r;
                rWord[fsp_pkg::STAT_PWM_BIT] = pwmLevel_r;
                rWord[fsp_pkg::STAT_FAN_BIT] = fanDrive_r;
            end
            default:          rWord = 32'h0000_0000;
        endcase
    end

    // One read in flight; data held until rready
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rValid_r <= 1'b0;
            rData_r  <= 32'h0000_0000;
            rResp_r  <= fsp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rValid_r) begin
            rValid_r <= 1'b1;
            rData_r  <= rWord;
            rResp_r  <= (rSel == FSP_SEL_NONE) ? fsp_pkg::RESP_SLVERR
                                               : fsp_pkg::RESP_OKAY;
        end else if (s_axi_rready) begin
            rValid_r <= 1'b0;
        end
    end

    // Counter advances on each divided tick and wraps at 256
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 8'h00;
        end else if (!enable_r) begin
            count_r <= 8'h00;
        end else if (divBus.cntTick) begin
            count_r <= count_r + 8'h01;
        end
    end

    // All ones forces full on; otherwise high while below duty
    always_comb begin
        pwmNxt = enable_r && ((duty_r == fsp_pkg::DUTY_FULL) ||
                              (count_r < duty_r));
    end

    // Output stage; inversion applies after the hold-low of disable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwmLevel_r <= 1'b0;
            fanDrive_r <= 1'b0;
        end else begin
            pwmLevel_r <= pwmNxt;
            fanDrive_r <= pwmNxt ^ invert_r;
        end
    end

    // Helper flags: registers untouched by software since reset
    logic presWritten_r;
    logic dutyWritten_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presWritten_r <= 1'b0;
            dutyWritten_r <= 1'b0;
        end else if (doWrite && wStrb0_r) begin
            if (wSel == FSP_SEL_PRESCALE) begin
                presWritten_r <= 1'b1;
            end
            if (wSel == FSP_SEL_DUTY) begin
                dutyWritten_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Counter step then wrap
    sequence tickAtTop;
        enable_r && divBus.cntTick && count_r == 8'hff;
    endsequence

    count_wrap_a: assert property (
        tickAtTop |=> count_r == 8'h00)
        else $error("counter did not wrap to zero");
    count_step_a: assert property (
        enable_r && divBus.cntTick |=> count_r == $past(count_r) + 8'h01)
        else $error("counter did not step on tick");
    pwm_compare_a: assert property (
        enable_r && duty_r != fsp_pkg::DUTY_FULL
            |=> pwmLevel_r == ($past(count_r) < $past(duty_r)))
        else $error("modulated level disagrees with compare");
    duty_zero_a: assert property (
        enable_r && duty_r == fsp_pkg::DUTY_ZERO |=> !pwmLevel_r)
        else $error("zero duty produced a high level");
    duty_full_a: assert property (
        enable_r && duty_r == fsp_pkg::DUTY_FULL |=> pwmLevel_r)
        else $error("full duty produced a low level");
    invert_out_a: assert property (
        ##1 (fanDrive_r ^ pwmLevel_r) == $past(invert_r))
        else $error("fan drive polarity wrong");
    sel_default_a: assert property (
        !presWritten_r |-> !prescale_r[fsp_pkg::CLK_SEL_BIT])
        else $error("clock select not fast after reset");
    duty_default_a: assert property (
        !dutyWritten_r |-> duty_r == fsp_pkg::DUTY_RESET)
        else $error("duty not all ones after reset");
    disable_hold_a: assert property (
        !enable_r |=> count_r == 8'h00 && !pwmLevel_r)
        else $error("disabled generator not held cleared");
endmodule
`default_nettype wire

// ==== verification/fsp_fan_model.sv ====
// Fan load model that times the drive waveform it receives
`timescale 1ns/100ps
`default_nettype none
module fsp_fan_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        fanDriveOutput,
    input  wire logic        clrMeas,
    output logic [31:0]      highCyc,
    output logic [31:0]      totCyc,
    output logic [31:0]      pulseCyc,
    output logic [31:0]      periodCyc
);
    logic        lastLvl_r;   // Level at the previous edge
    logic [31:0] sinceRise_r; // Cycles since the last rise

    // Edge timing: last full period and last high pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lastLvl_r   <= 1'b0;
            sinceRise_r <= 32'h0;
            pulseCyc    <= 32'h0;
            periodCyc   <= 32'h0;
        end else begin
            lastLvl_r <= fanDriveOutput;
            // Rise closes a period and opens the next
            if (fanDriveOutput && !lastLvl_r) begin
                periodCyc   <= sinceRise_r + 32'h1;
                sinceRise_r <= 32'h0;
            end else begin
                sinceRise_r <= sinceRise_r + 32'h1;
            end
            // Fall closes a high pulse
            if (!fanDriveOutput && lastLvl_r) begin
                pulseCyc <= sinceRise_r + 32'h1;
            end
        end
    end

    // Averaging window, restarted by the bench; no edges needed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            highCyc <= 32'h0;
            totCyc  <= 32'h0;
        end else if (clrMeas) begin
            highCyc <= 32'h0;
            totCyc  <= 32'h0;
        end else begin
            highCyc <= highCyc + {31'h0, fanDriveOutput};
            totCyc  <= totCyc + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/fan_speed_pwm_generator_test.sv ====
// Self-checking bench for the fan speed PWM generator
`timescale 1ns/100ps
`default_nettype none
module fan_speed_pwm_generator_test;
    // Fast source, divide by 3: counter ticks every this many cycles
    localparam int TICK3 = 3 * fsp_pkg::CLK_KHZ / fsp_pkg::SRC_FAST_KHZ;
    logic        mclk, rst_n;             // Clock and reset
    logic [3:0]  awAddr, arAddr;          // Bus addresses
    logic        awValid, awReady;        // Write address channel
    logic [31:0] wData, rData;            // Bus data
    logic [3:0]  wStrb;                   // Write strobes
    logic        wValid, wReady;          // Write data channel
    logic [1:0]  bResp, rResp;            // Responses
    logic        bValid, bReady;          // Write response channel
    logic        arValid, arReady;        // Read address channel
    logic        rValid, rReady;          // Read data channel
    logic        fan_drive_output, clrMeas;         // Drive line, window restart
    logic [31:0] highCyc, totCyc;         // Window counts
    logic [31:0] pulseCyc, periodCyc;     // Edge timing
    logic [31:0] data, cntA;              // Read results
    logic [1:0]  resp;                    // Read response
    logic [7:0]  dutyTab [4] = '{8'h01, 8'h40, 8'h80, 8'hfe}; // Duty codes
    int          failures, totalChecks;   // Scoreboard

    fsp_pwm_top #(.ADDR_W(4)) dut (
        .mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .fanDriveOutput(fan_drive_output));

    fsp_fan_model fan (
        .mclk(mclk), .rst_n(rst_n), .fanDriveOutput(fan_drive_output),
        .clrMeas(clrMeas), .highCyc(highCyc), .totCyc(totCyc),
        .pulseCyc(pulseCyc), .periodCyc(periodCyc));

    // Free-running 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h want %h",
                     $time, msg, seen, exp);
        end
    endtask

    // Jittered source: timings match within a tolerance
    function automatic logic near(input logic [31:0] seen, input int exp,
                                  input int tol);
        return (int'(seen) >= exp - tol) && (int'(seen) <= exp + tol);
    endfunction

    // Write with both channels offered together, response checked
    task automatic axiWrite(input logic [3:0] addr, input logic [31:0] dat,
                            input logic [3:0] strb, input logic [1:0] expR);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge mclk);
        awAddr <= addr;
        wData <= dat;
        wStrb <= strb;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            // Each channel released at its own handshake edge
            if (!awDone && awReady === 1'b1) begin
                awDone = 1'b1;
                awValid <= 1'b0;
            end
            if (!wDone && wReady === 1'b1) begin
                wDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        do @(posedge mclk); while (bValid !== 1'b1);
        bReady <= 1'b0;
        check(32'(bResp), 32'(expR), "write response");
    endtask

    // Plain full-word write expecting OKAY
    task automatic wr(input logic [3:0] addr, input logic [31:0] dat);
        axiWrite(addr, dat, 4'hf, fsp_pkg::RESP_OKAY);
    endtask

    // Read: address held to its handshake, data taken at rvalid edge
    task automatic axiRead(input logic [3:0] addr, output logic [31:0] dat,
                           output logic [1:0] rsp);
        @(posedge mclk);
        arAddr <= addr;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge mclk); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge mclk); while (rValid !== 1'b1);
        dat = rData;
        rsp = rResp;
        rReady <= 1'b0;
    endtask

    // Idle cycles and window restart
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic clearMeas;
        @(posedge mclk);
        clrMeas <= 1'b1;
        @(posedge mclk);
        clrMeas <= 1'b0;
    endtask

    // Counts and verdict, the single end of the run
    task automatic end_sim;
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, well beyond the ~30k cycles the tests need
    initial begin
        repeat (80000) @(posedge mclk);
        failures++;
        end_sim();
    end

    // Test sequence
    initial begin
        {awAddr, arAddr, awValid, wValid, arValid} = '0;
        {wData, wStrb, bReady, rReady, clrMeas} = '0;
        failures = 0;
        totalChecks = 0;
        rst_n = 1'b0;
        idle(4);
        rst_n <= 1'b1;
        // Reset values, refusals, read/write access
        axiRead(fsp_pkg::ADDR_PRESCALE, data, resp);
        check(data, {24'h0, fsp_pkg::PRESCALE_RESET}, "prescale");
        check(32'(resp), 32'(fsp_pkg::RESP_OKAY), "read response");
        axiRead(fsp_pkg::ADDR_DUTY, data, resp);
        check(data, {24'h0, fsp_pkg::DUTY_RESET}, "duty reset");
        axiRead(fsp_pkg::ADDR_CONTROL, data, resp);
        check(data, 32'h0, "control reset");
        check(32'(fan_drive_output), 32'h0, "idle drive");
        axiRead(4'h2, data, resp);
        check(32'(resp), 32'(fsp_pkg::RESP_SLVERR), "unmapped");
        check(data, 32'h0, "unmapped data");
        axiWrite(fsp_pkg::ADDR_STATUS, 32'hff, 4'hf, fsp_pkg::RESP_SLVERR);
        wr(fsp_pkg::ADDR_PRESCALE, 32'hffff_ff85);
        axiWrite(fsp_pkg::ADDR_PRESCALE, 32'h0, 4'h0, fsp_pkg::RESP_OKAY);
        axiRead(fsp_pkg::ADDR_PRESCALE, data, resp);
        check(data, 32'h85, "prescale rw");
        $display("test registers done");
        // Frequency set while disabled, then only duty changes
        wr(fsp_pkg::ADDR_PRESCALE, 32'h2);
        wr(fsp_pkg::ADDR_CONTROL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(fsp_pkg::ADDR_DUTY, {24'h0, dutyTab[i]});
            idle(4000);
            check(32'(near(pulseCyc, dutyTab[i] * TICK3, 2)), 32'h1,
                  "pulse width");
            check(32'(near(periodCyc, 256 * TICK3, 2)), 32'h1,
                  "period");
        end
        $display("test duty done");
        // Extreme codes: no edges, judged over a window
        wr(fsp_pkg::ADDR_DUTY, {24'h0, fsp_pkg::DUTY_ZERO});
        idle(1300);
        clearMeas();
        idle(1500);
        check(highCyc, 32'h0, "duty zero");
        wr(fsp_pkg::ADDR_DUTY, {24'h0, fsp_pkg::DUTY_FULL});
        idle(1300);
        clearMeas();
        idle(1500);
        check(highCyc, totCyc, "duty full");
        $display("test extremes done");
        // Inverted drive
        wr(fsp_pkg::ADDR_DUTY, 32'h40);
        wr(fsp_pkg::ADDR_CONTROL, 32'h3);
        idle(4000);
        check(32'(near(pulseCyc, (256 - 64) * TICK3, 2)), 32'h1,
              "inverted pulse");
        // Disable clears counter and levels
        wr(fsp_pkg::ADDR_CONTROL, 32'h0);
        idle(3);
        check(32'(fan_drive_output), 32'h0, "disabled drive");
        axiRead(fsp_pkg::ADDR_STATUS, data, resp);
        check(data, 32'h0, "disabled status");
        $display("test invert and disable done");
        // Zero field passes the fast source straight through
        wr(fsp_pkg::ADDR_PRESCALE, 32'h0);
        wr(fsp_pkg::ADDR_CONTROL, 32'h1);
        idle(2000);
        check(32'(near(periodCyc, 256 * fsp_pkg::CLK_KHZ /
              fsp_pkg::SRC_FAST_KHZ, 2)), 32'h1,
              "bypass period");
        // Slow source: counter rate from the live count
        wr(fsp_pkg::ADDR_CONTROL, 32'h0);
        wr(fsp_pkg::ADDR_PRESCALE, 32'h80);
        wr(fsp_pkg::ADDR_CONTROL, 32'h1);
        axiRead(fsp_pkg::ADDR_STATUS, cntA, resp);
        idle(2000);
        axiRead(fsp_pkg::ADDR_STATUS, data, resp);
        check(32'(near({24'h0, data[7:0] - cntA[7:0]},
              2000 / fsp_pkg::SLOW_GAP_CYC, 1)), 32'h1,
              "slow rate");
        $display("test clock sources done");
        end_sim();
    end
endmodule
`default_nettype wire
